//--- inc/stereo_sync_pkg.sv
package stereo_sync_pkg;

   // ----------------------------------------------------------------
   // clock and counter sizing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int CNT_W   = 20;

   // ----------------------------------------------------------------
   // timing figures in ns, as printed
   // ----------------------------------------------------------------
   localparam int BASE_NS      = 501000;   // strictly more than 500 us
   localparam int DELTA_NS     = 132000;   // nominal at 120 Hz input
   localparam int DELTA_MIN_NS = 128000;
   localparam int DELTA_MAX_NS = 163000;
   localparam int PULSE_NS     = 26000;    // nominal at 120 Hz input
   localparam int PULSE_MIN_NS = 20000;
   localparam int PULSE_MAX_NS = 32000;
   localparam int SHUT_ON_NS   = 2001000;  // strictly more than 2000 us

   // ----------------------------------------------------------------
   // cycle counts: least times round up, longest times round down
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] BASE_CYC_DEF      = CNT_W'((BASE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] DELTA_CYC_DEF     = CNT_W'((DELTA_NS * CLK_MHZ) / 1000);
   localparam logic [CNT_W-1:0] DELTA_MIN_CYC_DEF = CNT_W'((DELTA_MIN_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] DELTA_MAX_CYC_DEF = CNT_W'((DELTA_MAX_NS * CLK_MHZ) / 1000);
   localparam logic [CNT_W-1:0] PULSE_CYC_DEF     = CNT_W'((PULSE_NS * CLK_MHZ) / 1000);
   localparam logic [CNT_W-1:0] PULSE_MIN_CYC_DEF = CNT_W'((PULSE_MIN_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] PULSE_MAX_CYC_DEF = CNT_W'((PULSE_MAX_NS * CLK_MHZ) / 1000);
   localparam logic [CNT_W-1:0] SHUT_ON_CYC_DEF   = CNT_W'((SHUT_ON_NS * CLK_MHZ + 999) / 1000);

   // ----------------------------------------------------------------
   // reset values and encodings
   // ----------------------------------------------------------------
   localparam logic EYE_RST = 1'b0;   // 0 = left eye phase, 1 = right eye phase

   typedef enum logic [1:0] {
      COLOR_RED   = 2'h0,
      COLOR_GREEN = 2'h1,
      COLOR_BLUE  = 2'h2
   } color_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_DARK  = 3'h1,
      ST_PULSE = 3'h3,
      ST_GAP   = 3'h2,
      ST_OPEN  = 3'h6
   } sync_state_t;

endpackage

//--- verilog/window_timer.sv
`timescale 1ns/100ps
module window_timer
   import stereo_sync_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         mclk_in,
   input  wire logic         rst_n_in,
   input  wire logic         ce_in,
   input  wire logic         start_in,
   input  wire logic [W-1:0] offset_in,
   input  wire logic [W-1:0] width_in,
   output logic              active_out,
   output logic              fire_out
);

   // ----------------------------------------------------------------
   // elapsed count since start, saturating
   // ----------------------------------------------------------------
   logic [W-1:0] count_ff;
   logic         run_ff;
   logic         active_ff;
   logic         fire_ff;
   logic [W:0]   win_end;
   wire          in_win;
   wire          at_off;
   wire          cnt_max;

   assign win_end = {1'b0, offset_in} + {1'b0, width_in};
   assign in_win  = run_ff && (count_ff >= offset_in) && ({1'b0, count_ff} < win_end);
   assign at_off  = run_ff && (count_ff == offset_in);
   assign cnt_max = &count_ff;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         count_ff  <= '0;
         run_ff    <= 1'b0;
         active_ff <= 1'b0;
         fire_ff   <= 1'b0;
      end else if (ce_in) begin
         // a new start restarts the window even mid-pulse
         if (start_in) begin
            count_ff <= '0;
            run_ff   <= 1'b1;
         end else if (run_ff && !cnt_max) begin
            count_ff <= count_ff + 1'b1;
         end
         active_ff <= in_win && !start_in;
         fire_ff   <= at_off && !start_in;
      end
   end

   assign active_out = active_ff;
   assign fire_out   = fire_ff;

endmodule

//--- verilog/stereo_sync_gen.sv
`timescale 1ns/100ps
//Function
// [RULE1] with stereo input active, align shutter switching with displayed mirror frames
// [RULE2] drive a dedicated sync output for a board infrared transmitter
// [RULE3] exactly one light pulse per frame, while both shutters are closed
// [RULE4] tell the illumination driver when to switch the source on for the pulse
// [RULE5] keep illumination off while both shutters closed, except during the pulse
// [RULE6] any pulse colour allowed; red preferred, blue avoided
// [RULE7] pulse lies after both shutters close and before next shutter opens
// [RULE8] pulse offset alternates between base (over 500 us) and base plus delta
// [RULE9] pulse width held between 20 and 32 us, nominal 26 us
// [RULE10] delta offset held between 128 and 163 us, nominal 132 us
// [RULE11] total offset always equals base plus delta
// [RULE12] eye flag toggles each frame, selects shutter phase and offset
module stereo_sync_gen
   import stereo_sync_pkg::*;
#(
   parameter logic [CNT_W-1:0] BASE_CYC      = BASE_CYC_DEF,
   parameter logic [CNT_W-1:0] DELTA_CYC     = DELTA_CYC_DEF,
   parameter logic [CNT_W-1:0] DELTA_MIN_CYC = DELTA_MIN_CYC_DEF,
   parameter logic [CNT_W-1:0] DELTA_MAX_CYC = DELTA_MAX_CYC_DEF,
   parameter logic [CNT_W-1:0] PULSE_CYC     = PULSE_CYC_DEF,
   parameter logic [CNT_W-1:0] PULSE_MIN_CYC = PULSE_MIN_CYC_DEF,
   parameter logic [CNT_W-1:0] PULSE_MAX_CYC = PULSE_MAX_CYC_DEF,
   parameter logic [CNT_W-1:0] SHUT_ON_CYC   = SHUT_ON_CYC_DEF
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_n_in,
   input  wire logic             ce_in,
   input  wire logic             stereo_en_in,
   input  wire logic             frame_start_in,
   input  wire logic             video_illum_in,
   input  wire logic [CNT_W-1:0] pulse_width_in,
   input  wire logic [CNT_W-1:0] delta_in,
   input  wire logic [1:0]       pulse_color_in,
   output logic                  eye_sel_out,
   output logic                  left_shutter_out,
   output logic                  right_shutter_out,
   output logic                  ir_sync_out,
   output logic                  illum_on_out,
   output logic [1:0]            illum_color_out,
   output logic [CNT_W-1:0]      total_offset_out
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [CNT_W-1:0] clamp(input logic [CNT_W-1:0] v,
                                              input logic [CNT_W-1:0] lo,
                                              input logic [CNT_W-1:0] hi);
      logic [CNT_W-1:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // stereo enable comes from a pin: two flops before use
   // ----------------------------------------------------------------
   logic stereo_meta_ff;
   logic stereo_ff;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         stereo_meta_ff <= 1'b0;
         stereo_ff      <= 1'b0;
      end else if (ce_in) begin
         stereo_meta_ff <= stereo_en_in;
         stereo_ff      <= stereo_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // timing selection
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] pulse_req;
   logic [CNT_W-1:0] delta_req;
   logic [CNT_W-1:0] pulse_w;
   logic [CNT_W-1:0] delta_w;
   logic [CNT_W-1:0] total_off;
   logic [CNT_W-1:0] pulse_off;
   logic [CNT_W-1:0] one_cyc;
   logic             eye_ff;
   logic             nxt_eye;
   wire              frame_go;

   // zero on a config input means use the nominal figure
   assign pulse_req = (pulse_width_in == '0) ? PULSE_CYC : pulse_width_in;
   assign delta_req = (delta_in == '0) ? DELTA_CYC : delta_in;
   // [RULE9] clamp pulse width
   assign pulse_w   = clamp(pulse_req, PULSE_MIN_CYC, PULSE_MAX_CYC);
   // [RULE10] clamp delta offset
   assign delta_w   = clamp(delta_req, DELTA_MIN_CYC, DELTA_MAX_CYC);
   // [RULE11] total is base plus delta
   assign total_off = BASE_CYC + delta_w;
   // [RULE8] alternate base and base plus delta
   assign pulse_off = eye_ff ? total_off : BASE_CYC;
   assign one_cyc   = {{(CNT_W-1){1'b0}}, 1'b1};
   assign frame_go  = stereo_ff && frame_start_in;
   // [RULE12] eye flag toggles per frame
   assign nxt_eye   = frame_go ? !eye_ff : eye_ff;

   // ----------------------------------------------------------------
   // timers: one for the light pulse, one for the shutter opening
   // ----------------------------------------------------------------
   logic pulse_active;
   logic open_fire;

   // offsets are sampled with the eye flag already toggled: the timers see
   // the new phase one cycle after the frame start, before any compare hits
   window_timer #(
      .W          (CNT_W)
   ) u_pulse_timer (
      .mclk_in    (mclk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .start_in   (frame_go),
      .offset_in  (pulse_off),
      .width_in   (pulse_w),
      .active_out (pulse_active),
      .fire_out   ()
   );

   window_timer #(
      .W          (CNT_W)
   ) u_open_timer (
      .mclk_in    (mclk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .start_in   (frame_go),
      .offset_in  (SHUT_ON_CYC),
      .width_in   (one_cyc),
      .active_out (),
      .fire_out   (open_fire)
   );

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   sync_state_t state_ff;
   sync_state_t nxt_state;
   logic        pulse_done_ff;
   logic        nxt_pulse_done;

   always_comb begin
      nxt_state      = state_ff;
      nxt_pulse_done = pulse_done_ff;
      if (!stereo_ff) begin
         nxt_state = ST_IDLE;
      end else if (frame_start_in) begin
         // [RULE1] frame boundary closes both shutters
         nxt_state      = ST_DARK;
         nxt_pulse_done = 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               nxt_state = ST_IDLE;
            end
            ST_DARK: begin
               // [RULE3] only one pulse per frame
               if (pulse_active && !pulse_done_ff) begin
                  nxt_state = ST_PULSE;
               end
            end
            ST_PULSE: begin
               if (!pulse_active) begin
                  nxt_state      = ST_GAP;
                  nxt_pulse_done = 1'b1;
               end
            end
            ST_GAP: begin
               // [RULE7] shutter opens only after the pulse
               if (open_fire) begin
                  nxt_state = ST_OPEN;
               end
            end
            ST_OPEN: begin
               nxt_state = ST_OPEN;
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // output decode
   // ----------------------------------------------------------------
   logic       nxt_left;
   logic       nxt_right;
   logic       nxt_illum;
   logic [1:0] nxt_color;
   logic       closed;

   assign closed    = (nxt_state == ST_DARK) || (nxt_state == ST_PULSE) ||
                      (nxt_state == ST_GAP);
   // [RULE1] open shutter matches eye phase
   assign nxt_left  = (nxt_state == ST_OPEN) && !nxt_eye;
   assign nxt_right = (nxt_state == ST_OPEN) && nxt_eye;
   // [RULE5] dark while closed except during pulse
   assign nxt_illum = (nxt_state == ST_PULSE) ? 1'b1 :
                      closed ? 1'b0 : video_illum_in;
   // [RULE6] blue request is replaced by red
   assign nxt_color = (nxt_state != ST_PULSE) ? COLOR_RED :
                      (pulse_color_in == COLOR_BLUE) ? COLOR_RED :
                      (pulse_color_in == COLOR_GREEN) ? COLOR_GREEN : COLOR_RED;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic             left_ff;
   logic             right_ff;
   logic             ir_ff;
   logic             illum_ff;
   logic [1:0]       color_ff;
   logic [CNT_W-1:0] total_ff;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_ff      <= ST_IDLE;
         pulse_done_ff <= 1'b0;
         eye_ff        <= EYE_RST;
      end else if (ce_in) begin
         state_ff      <= nxt_state;
         pulse_done_ff <= nxt_pulse_done;
         eye_ff        <= nxt_eye;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         left_ff  <= 1'b0;
         right_ff <= 1'b0;
         ir_ff    <= 1'b0;
         illum_ff <= 1'b0;
         color_ff <= COLOR_RED;
         total_ff <= '0;
      end else if (ce_in) begin
         left_ff  <= nxt_left;
         right_ff <= nxt_right;
         // [RULE2] infrared sync follows eye phase
         ir_ff    <= stereo_ff && nxt_eye;
         // [RULE4] illumination drive for the pulse
         illum_ff <= nxt_illum;
         color_ff <= nxt_color;
         total_ff <= total_off;
      end
   end

   assign eye_sel_out       = eye_ff;
   assign left_shutter_out  = left_ff;
   assign right_shutter_out = right_ff;
   assign ir_sync_out       = ir_ff;
   assign illum_on_out      = illum_ff;
   assign illum_color_out   = color_ff;
   assign total_offset_out  = total_ff;

endmodule

//--- dv/light_driver_model.sv
`timescale 1ns/100ps
module light_driver_model
   import stereo_sync_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       lamp_en_in,
   input  wire logic [1:0] lamp_color_in,
   input  wire logic       ir_in,
   output logic [2:0]      lamp_out,
   output logic            ir_led_out
);
   // ----------------------------------------
   // emitters: red, green, blue one-hot
   // ----------------------------------------
   // the driver switches one clock late, like a real gate driver stage
   always_ff @(posedge mclk_in) begin
      lamp_out   <= lamp_en_in ? 3'h1 << lamp_color_in : 3'h0;
      ir_led_out <= ir_in;
   end
endmodule

//--- dv/stereo_sync_gen_sva.sv
`timescale 1ns/100ps
module stereo_sync_chk
   import stereo_sync_pkg::*;
#(
   parameter logic [CNT_W-1:0] BASE_CYC      = BASE_CYC_DEF,
   parameter logic [CNT_W-1:0] DELTA_CYC     = DELTA_CYC_DEF,
   parameter logic [CNT_W-1:0] DELTA_MIN_CYC = DELTA_MIN_CYC_DEF,
   parameter logic [CNT_W-1:0] DELTA_MAX_CYC = DELTA_MAX_CYC_DEF,
   parameter logic [CNT_W-1:0] PULSE_MIN_CYC = PULSE_MIN_CYC_DEF,
   parameter logic [CNT_W-1:0] PULSE_MAX_CYC = PULSE_MAX_CYC_DEF,
   parameter logic [CNT_W-1:0] SHUT_ON_CYC   = SHUT_ON_CYC_DEF
) (
   input wire logic             mclk_in,
   input wire logic             rst_n_in,
   input wire logic             ce_in,
   input wire logic             stereo_en_in,
   input wire logic             frame_start_in,
   input wire logic             video_illum_in,
   input wire logic [CNT_W-1:0] pulse_width_in,
   input wire logic [CNT_W-1:0] delta_in,
   input wire logic [1:0]       pulse_color_in,
   input wire logic             eye_sel_out,
   input wire logic             left_shutter_out,
   input wire logic             right_shutter_out,
   input wire logic             ir_sync_out,
   input wire logic             illum_on_out,
   input wire logic [1:0]       illum_color_out,
   input wire logic [CNT_W-1:0] total_offset_out
);
   // ----------------------------------------
   // frame tracking
   // ----------------------------------------
   logic [2:0]       sh_ff;
   logic             seen_ff;
   logic [CNT_W-1:0] since_ff;
   logic [CNT_W-1:0] run_ff;
   // one stage more than the design's sync, so a frame seen here is surely taken there
   wire              frm_w  = ce_in && frame_start_in && stereo_en_in && (&sh_ff);
   wire              dark_w = seen_ff && !left_shutter_out && !right_shutter_out && since_ff != '0;
   wire [CNT_W-1:0]  dcl_w  = (delta_in == '0) ? DELTA_CYC : (delta_in < DELTA_MIN_CYC) ?
      DELTA_MIN_CYC : (delta_in > DELTA_MAX_CYC) ? DELTA_MAX_CYC : delta_in;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sh_ff    <= 3'h0;
         seen_ff  <= 1'b0;
         since_ff <= '0;
         run_ff   <= '0;
      end else if (ce_in) begin
         sh_ff    <= {sh_ff[1:0], stereo_en_in};
         seen_ff  <= frm_w || (seen_ff && stereo_en_in);
         since_ff <= frm_w ? '0 : since_ff + 1'b1;
         run_ff   <= illum_on_out ? run_ff + 1'b1 : '0;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sequence frame_s;
      frm_w;
   endsequence
   sequence rise_s;
      $rose(illum_on_out) && dark_w;
   endsequence
   sequence fall_s;
      $fell(illum_on_out) && dark_w;
   endsequence
   eye_toggle_a: assert property (frame_s |=> eye_sel_out != $past(eye_sel_out))
      else $error("eye flag kept on frame start");
   frame_dark_a: assert property (frame_s |=>
      !(left_shutter_out || right_shutter_out || illum_on_out))
      else $error("not dark after frame start");
   ir_eye_a: assert property (seen_ff |-> ir_sync_out == eye_sel_out)
      else $error("infrared sync differs from eye flag");
   shut_eye_a: assert property ((left_shutter_out || right_shutter_out) |->
      right_shutter_out == eye_sel_out && left_shutter_out != right_shutter_out)
      else $error("wrong shutter open");
   shut_delay_a: assert property ($rose(left_shutter_out || right_shutter_out) |->
      seen_ff && since_ff >= SHUT_ON_CYC)
      else $error("shutter opened early");
   pulse_offset_a: assert property (rise_s |-> eye_sel_out ?
      (since_ff >= BASE_CYC + DELTA_MIN_CYC && since_ff <= BASE_CYC + DELTA_MAX_CYC + 2) :
      (since_ff >= BASE_CYC && since_ff <= BASE_CYC + 2))
      else $error("pulse offset out of range");
   pulse_width_a: assert property (fall_s |->
      run_ff >= PULSE_MIN_CYC && run_ff <= PULSE_MAX_CYC)
      else $error("pulse width out of range");
   color_safe_a: assert property (illum_on_out && dark_w |->
      illum_color_out == COLOR_RED || illum_color_out == COLOR_GREEN)
      else $error("pulse colour not red or green");
   color_idle_a: assert property (!illum_on_out |-> illum_color_out == 2'h0)
      else $error("colour set while source off");
   total_off_a: assert property ((ce_in && $stable(delta_in)) [*4] |->
      total_offset_out == BASE_CYC + dcl_w)
      else $error("total offset not base plus delta");
endmodule
bind stereo_sync_gen stereo_sync_chk #(
   .BASE_CYC(BASE_CYC), .DELTA_CYC(DELTA_CYC), .DELTA_MIN_CYC(DELTA_MIN_CYC),
   .DELTA_MAX_CYC(DELTA_MAX_CYC), .PULSE_MIN_CYC(PULSE_MIN_CYC),
   .PULSE_MAX_CYC(PULSE_MAX_CYC), .SHUT_ON_CYC(SHUT_ON_CYC)
) stereo_sync_chk_inst (
   .mclk_in           (mclk_in),
   .rst_n_in          (rst_n_in),
   .ce_in             (ce_in),
   .stereo_en_in      (stereo_en_in),
   .frame_start_in    (frame_start_in),
   .video_illum_in    (video_illum_in),
   .pulse_width_in    (pulse_width_in),
   .delta_in          (delta_in),
   .pulse_color_in    (pulse_color_in),
   .eye_sel_out       (eye_sel_out),
   .left_shutter_out  (left_shutter_out),
   .right_shutter_out (right_shutter_out),
   .ir_sync_out       (ir_sync_out),
   .illum_on_out      (illum_on_out),
   .illum_color_out   (illum_color_out),
   .total_offset_out  (total_offset_out)
);

//--- dv/stereo_sync_gen_tb.sv
`timescale 1ns/100ps
module stereo_sync_gen_tb;
   import stereo_sync_pkg::*;
   localparam int B_P = 32'h14, D_P = 32'h6, DMN_P = 32'h4, DMX_P = 32'h8;
   localparam int W_P = 32'h3, WMN_P = 32'h2, WMX_P = 32'h4, S_P = 32'h3C;
   logic             mclk_in, rst_n_in, ce_in, stereo_en_in, frame_start_in, video_illum_in;
   logic             eye_sel_out, left_shutter_out, right_shutter_out, ir_sync_out, illum_on_out;
   logic             ir_led_out;
   logic [1:0]       pulse_color_in, illum_color_out;
   logic [2:0]       lamp;
   logic [CNT_W-1:0] pulse_width_in, delta_in, total_offset_out;
   int               n_errors, samples_checked, r0, e;
   stereo_sync_gen #(
      .BASE_CYC(CNT_W'(B_P)), .DELTA_CYC(CNT_W'(D_P)), .DELTA_MIN_CYC(CNT_W'(DMN_P)),
      .DELTA_MAX_CYC(CNT_W'(DMX_P)), .PULSE_CYC(CNT_W'(W_P)), .PULSE_MIN_CYC(CNT_W'(WMN_P)),
      .PULSE_MAX_CYC(CNT_W'(WMX_P)), .SHUT_ON_CYC(CNT_W'(S_P))
   ) stereo_sync_gen_inst (
      .mclk_in           (mclk_in),
      .rst_n_in          (rst_n_in),
      .ce_in             (ce_in),
      .stereo_en_in      (stereo_en_in),
      .frame_start_in    (frame_start_in),
      .video_illum_in    (video_illum_in),
      .pulse_width_in    (pulse_width_in),
      .delta_in          (delta_in),
      .pulse_color_in    (pulse_color_in),
      .eye_sel_out       (eye_sel_out),
      .left_shutter_out  (left_shutter_out),
      .right_shutter_out (right_shutter_out),
      .ir_sync_out       (ir_sync_out),
      .illum_on_out      (illum_on_out),
      .illum_color_out   (illum_color_out),
      .total_offset_out  (total_offset_out)
   );
   light_driver_model light_driver_model_inst (.mclk_in(mclk_in), .lamp_en_in(illum_on_out),
      .lamp_color_in(illum_color_out), .ir_in(ir_sync_out), .lamp_out(lamp),
      .ir_led_out(ir_led_out));
   // ----------------------------------------
   // model and checks
   // ----------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end
   function automatic int clampv(int v, int nom, int lo, int hi);
      return v == 0 ? nom : v < lo ? lo : v > hi ? hi : v;
   endfunction
   // wide enough to hold colour and offset in one compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge mclk_in);
      #1;
   endtask
   task automatic rst_chk();
      chk({eye_sel_out, left_shutter_out, right_shutter_out, ir_sync_out, illum_on_out}, 0);
      chk({illum_color_out, total_offset_out}, 0);
   endtask
   // frames shorter than the shutter delay stay dark to the end
   task automatic frame(input int len, input bit st, input int col);
      int   pw, dl, hi, rs, ri, eye;
      logic pv, pi, po, op;
      pw = $urandom % 6;
      dl = $urandom % 10;
      eye = eye_sel_out;
      pulse_width_in = CNT_W'(pw);
      delta_in = CNT_W'(dl);
      pulse_color_in = 2'(col);
      frame_start_in = 1'b1;
      pv = video_illum_in;
      hi = 0;
      rs = 0;
      ri = 0;
      pi = 1'b0;
      po = 1'b0;
      tick();
      frame_start_in = 1'b0;
      for (int i = 1; i < len; i++) begin
         op = left_shutter_out || right_shutter_out;
         if (!st) chk({left_shutter_out, right_shutter_out, illum_on_out}, {2'h0, pv});
         else if (op && po) chk(illum_on_out, pv);
         else if (!op) begin
            hi += illum_on_out;
            if (pi && i == ri + 1) chk(lamp, col == 1 ? 3'h2 : 3'h1);
            if (illum_on_out && !pi) begin
               rs++;
               ri = i;
               chk(illum_color_out, col == 1 ? 2'h1 : 2'h0);
            end
            pi = illum_on_out;
         end
         po = op;
         video_illum_in = 1'($urandom);
         pv = video_illum_in;
         tick();
      end
      if (st) begin
         chk(eye_sel_out, !eye);
         chk(ir_led_out, !eye);
         chk(rs, 1);
         chk(hi, clampv(pw, W_P, WMN_P, WMX_P));
         chk(total_offset_out, B_P + clampv(dl, D_P, DMN_P, DMX_P));
         chk({left_shutter_out, right_shutter_out},
             len < S_P + 10 ? 0 : eye ? 2 : 1);
         // window opens one edge after the count, source switches one edge later
         if (eye) chk(ri, B_P + 3);
         else if (r0 > 0) chk(ri - r0, clampv(dl, D_P, DMN_P, DMX_P));
         if (eye) r0 = ri;
      end else chk(eye_sel_out, eye);
   endtask
   task automatic results();
      $display("checked=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      results();
   end
   initial begin
      void'($urandom(32'h6CF3));
      {rst_n_in, ce_in, stereo_en_in, frame_start_in, video_illum_in} = 5'h08;
      pulse_width_in = '0;
      delta_in = '0;
      pulse_color_in = 2'h0;
      repeat (20) tick();
      rst_chk();
      rst_n_in = 1'b1;
      tick();
      repeat (3) frame(45, 0, 0);
      $display("test stereo_off done");
      stereo_en_in = 1'b1;
      repeat (4) tick();
      for (int i = 0; i < 12; i++) frame($urandom % 2 ? 80 : 45, 1, i % 4);
      $display("test stereo_frames done");
      e = eye_sel_out;
      ce_in = 1'b0;
      frame_start_in = 1'b1;
      repeat (3) tick();
      chk(eye_sel_out, e);
      ce_in = 1'b1;
      frame(80, 1, 1);
      $display("test clock_enable done");
      rst_n_in = 1'b0;
      repeat (2) tick();
      rst_chk();
      rst_n_in = 1'b1;
      repeat (4) tick();
      repeat (2) frame(80, 1, 2);
      $display("test mid_reset done");
      stereo_en_in = 1'b0;
      repeat (4) tick();
      frame(45, 0, 3);
      $display("test stereo_drop done");
      results();
   end
endmodule
